// File: imi_decoder.sv
// Decoder and sequencer for the two indexed move instructions.
//
// Functional notes
// RULE1: Addresses are frame pointer plus 7-bit offsets.
// RULE2: Addresses reach the whole 4096-byte data space.
// RULE3: Decode first and second word encodings exactly.
// RULE4: Software avoids program counter and stack destinations.
// RULE5: Indirect source address reads back a zero.
// RULE6: Indirect destination address makes the move a no-op; the code does this for the indexed move only, a file move still writes.
// RULE7: Source in cycle one, destination in cycle two.
// RULE8: File move second cycle writes only in Q4.
// RULE9: No pointer or flag change; lone second word idles.
`timescale 1ns/1ps
`default_nettype none

module imi_decoder #(
    parameter logic [11:0] IND_ADDR_LO = 12'hfe0, // Lowest indirect register address.
    parameter logic [11:0] IND_ADDR_HI = 12'hfef  // Highest indirect register address.
) (
    input  wire logic                        clk_sys_i,     // System clock, 250 MHz.
    input  wire logic                        rst_i,         // Synchronous reset, active high.
    input  wire logic                        instr_valid_i, // Program word present in Q1.
    input  wire logic [imi_pkg::WORD_W-1:0]  instr_word_i,  // Program word from the fetch path.
    input  wire logic [imi_pkg::ADDR_W-1:0]  frame_ptr_i,   // Current frame pointer value.
    input  wire logic [imi_pkg::DATA_W-1:0]  mem_rd_data_i, // Read data, valid in the read cycle.
    output logic      [1:0]                  q_phase_o,     // Current instruction cycle phase.
    output logic                             claim_o,       // Word taken by this block in Q1.
    output logic                             busy_o,        // An indexed move is in flight.
    output logic      [imi_pkg::ADDR_W-1:0]  mem_addr_o,    // Data memory address.
    output logic                             mem_rd_o,      // Read strobe in Q4.
    output logic                             mem_wr_o,      // Write strobe in Q4.
    output logic      [imi_pkg::DATA_W-1:0]  mem_wr_data_o  // Write data.
);
    import imi_pkg::*;

    // ****************************************************************
    // State.
    // ****************************************************************
    logic [1:0]          phase_ff;   // Free running phase counter.
    imi_state_t          state_ff;   // Sequencer state.
    logic                to_idx_ff;  // High for indexed to indexed, low for indexed to file.
    logic [OFFS_W-1:0]   offs_ff;    // Offset of the current address step.
    logic [ADDR_W-1:0]   file_ff;    // Direct destination for the file move.
    logic [ADDR_W-1:0]   addr_ff;    // Computed address, stable in Q4.
    logic [DATA_W-1:0]   data_ff;    // Byte carried from the read to the write.
    logic                ind_ff;     // Computed address is an indirect register.
    logic [ADDR_W-1:0]   sum;        // Frame pointer plus offset.
    logic                sum_ind;    // Sum falls on an indirect register.
    logic                q1_take;    // A word is offered in the decode phase.
    logic                first_hit;  // Offered word is a first word of ours.
    logic                second_hit; // Offered word is a second word.

    // Address sum, twelve bits wide so it wraps inside the data space.
    // RULE1: frame pointer offset
    // RULE2: full space reach
    assign sum     = ADDR_W'(frame_ptr_i + {{(ADDR_W-OFFS_W){1'b0}}, offs_ff});
    assign sum_ind = (sum >= IND_ADDR_LO) && (sum <= IND_ADDR_HI);

    // Decode of the offered word.
    // RULE3: opcode match
    assign q1_take    = instr_valid_i && (phase_ff == PH_Q1);
    assign first_hit  = (instr_word_i[OPC_HI:OPC9_LO] == OPC_IDX_TO_IDX)
                     || (instr_word_i[OPC_HI:OPC9_LO] == OPC_IDX_TO_FILE);
    assign second_hit = (instr_word_i[OPC_HI:OPC4_LO] == OPC_SECOND_WORD);

    // ****************************************************************
    // Phase counter.
    // ****************************************************************
    // The four phases step once per clock and wrap from Q4 to Q1.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            phase_ff <= PH_Q1;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
    end

    // ****************************************************************
    // Sequencer.
    // ****************************************************************
    // Words are only examined in Q1; the state holds for the other phases.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff  <= IMI_IDLE;
            to_idx_ff <= 1'b0;
            offs_ff   <= '0;
            file_ff   <= '0;
        end else if (phase_ff == PH_Q1) begin
            case (state_ff)
                IMI_IDLE: begin
                    // RULE9: lone second word
                    if (q1_take && first_hit) begin
                        state_ff  <= IMI_SRC;
                        to_idx_ff <= (instr_word_i[OPC_HI:OPC9_LO] == OPC_IDX_TO_IDX);
                        offs_ff   <= instr_word_i[OFFS_HI:0];
                    end
                end
                IMI_SRC: begin
                    // RULE7: enter second cycle
                    if (q1_take && second_hit) begin
                        state_ff <= IMI_DST;
                        offs_ff  <= instr_word_i[OFFS_HI:0];
                        file_ff  <= instr_word_i[FILE_HI:0];
                    end else begin
                        // A missing second word drops the move with no write.
                        state_ff <= IMI_IDLE;
                    end
                end
                IMI_DST: begin
                    // The move is done; a new first word may start at once.
                    if (q1_take && first_hit) begin
                        state_ff  <= IMI_SRC;
                        to_idx_ff <= (instr_word_i[OPC_HI:OPC9_LO] == OPC_IDX_TO_IDX);
                        offs_ff   <= instr_word_i[OFFS_HI:0];
                    end else begin
                        state_ff <= IMI_IDLE;
                    end
                end
                default: begin
                    state_ff <= IMI_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Address step.
    // ****************************************************************
    // The address is settled over Q2 and Q3 and registered at the end of Q3.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            addr_ff <= '0;
            ind_ff  <= 1'b0;
        end else if (phase_ff == PH_Q3) begin
            if (state_ff == IMI_SRC) begin
                // RULE7: source address
                addr_ff <= sum;
                ind_ff  <= sum_ind;
            end else if (state_ff == IMI_DST && to_idx_ff) begin
                // RULE7: destination address
                addr_ff <= sum;
                ind_ff  <= sum_ind;
            end else if (state_ff == IMI_DST) begin
                // RULE8: direct file address, no read
                addr_ff <= file_ff;
                ind_ff  <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Data carry.
    // ****************************************************************
    // The source byte is caught at the end of the first cycle's Q4.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            data_ff <= ZERO_BYTE;
        end else if (phase_ff == PH_Q4 && state_ff == IMI_SRC) begin
            // RULE5: indirect source reads zero
            data_ff <= ind_ff ? ZERO_BYTE : mem_rd_data_i;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    // Strobes appear in Q4 only; nothing here drives the frame pointer or flags.
    assign q_phase_o     = phase_ff;
    assign busy_o        = (state_ff != IMI_IDLE);
    assign claim_o       = q1_take && (first_hit || (second_hit && state_ff == IMI_SRC));
    assign mem_addr_o    = addr_ff;
    assign mem_wr_data_o = data_ff;
    assign mem_rd_o      = (phase_ff == PH_Q4) && (state_ff == IMI_SRC) && !ind_ff;
    // RULE6: indirect destination suppresses write
    assign mem_wr_o      = (phase_ff == PH_Q4) && (state_ff == IMI_DST) && !ind_ff;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    // Source address taken in Q3 equals frame pointer plus offset.
    property p_src_addr;
        @(posedge clk_sys_i) disable iff (rst_i)
        (phase_ff == PH_Q3 && state_ff == IMI_SRC)
        |=> mem_addr_o == ADDR_W'($past(frame_ptr_i) + {5'h00, $past(offs_ff)});
    endproperty
    a_src_addr: assert property (p_src_addr) else $error("Source address mismatch."); // RULE1

    // Destination address of the indexed move wraps in twelve bits.
    property p_dst_addr;
        @(posedge clk_sys_i) disable iff (rst_i)
        (phase_ff == PH_Q3 && state_ff == IMI_DST && to_idx_ff)
        |=> mem_addr_o == ADDR_W'($past(frame_ptr_i) + {5'h00, $past(offs_ff)});
    endproperty
    a_dst_addr: assert property (p_dst_addr) else $error("Destination address mismatch."); // RULE2

    // A first word offered when idle starts the source cycle.
    property p_decode;
        @(posedge clk_sys_i) disable iff (rst_i)
        (q1_take && state_ff == IMI_IDLE && first_hit) |=> (state_ff == IMI_SRC) [*4];
    endproperty
    a_decode: assert property (p_decode) else $error("First word not decoded."); // RULE3

    // An indirect source leaves a zero byte to be written.
    property p_src_zero;
        @(posedge clk_sys_i) disable iff (rst_i)
        (phase_ff == PH_Q4 && state_ff == IMI_SRC && ind_ff) |-> !mem_rd_o ##1 data_ff == ZERO_BYTE;
    endproperty
    a_src_zero: assert property (p_src_zero) else $error("Indirect source not zero."); // RULE5

    // An indirect destination of the indexed move produces no write.
    property p_dst_nop;
        @(posedge clk_sys_i) disable iff (rst_i)
        (state_ff == IMI_DST && to_idx_ff && phase_ff == PH_Q4 && ind_ff) |-> !mem_wr_o;
    endproperty
    a_dst_nop: assert property (p_dst_nop) else $error("Write to indirect destination."); // RULE6

    // Read in the first cycle, then the write four clocks later.
    // The state only turns to the second cycle at the end of its Q1, so it is seen in Q2.
    sequence s_read_done;
        (phase_ff == PH_Q4 && state_ff == IMI_SRC) ##2 (state_ff == IMI_DST);
    endsequence
    property p_rd_then_wr;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_read_done |-> ##2 (phase_ff == PH_Q4 && (mem_wr_o || ind_ff) && mem_wr_data_o == $past(data_ff, 3));
    endproperty
    a_rd_then_wr: assert property (p_rd_then_wr) else $error("Write not in second Q4."); // RULE7

    // The file move second cycle is silent in Q2 and Q3.
    property p_file_quiet;
        @(posedge clk_sys_i) disable iff (rst_i)
        (state_ff == IMI_DST && !to_idx_ff && phase_ff == PH_Q2) |-> (!mem_rd_o && !mem_wr_o) [*2] ##1 mem_wr_o;
    endproperty
    a_file_quiet: assert property (p_file_quiet) else $error("File move second cycle wrong."); // RULE8

    // A second word seen alone leaves the block idle.
    property p_lone_second;
        @(posedge clk_sys_i) disable iff (rst_i)
        (q1_take && state_ff == IMI_IDLE && second_hit) |-> !claim_o ##1 (state_ff == IMI_IDLE && !mem_wr_o) [*4];
    endproperty
    a_lone_second: assert property (p_lone_second) else $error("Lone second word not ignored."); // RULE9

endmodule

`default_nettype wire

// File: imi_pkg.sv
// Package of constants and types for the indexed move instruction block.
package imi_pkg;

    // ****************************************************************
    // Widths.
    // ****************************************************************
    localparam int unsigned ADDR_W = 12; // Data memory address width, 4096 bytes.
    localparam int unsigned DATA_W = 8;  // Data memory byte width.
    localparam int unsigned WORD_W = 16; // Program word width.
    localparam int unsigned OFFS_W = 7;  // Literal offset width.

    // ****************************************************************
    // Instruction encodings.
    // ****************************************************************
    localparam logic [8:0] OPC_IDX_TO_IDX = 9'h1d7; // First word top bits 1110 1011 1.
    localparam logic [8:0] OPC_IDX_TO_FILE = 9'h1d6; // First word top bits 1110 1011 0.
    localparam logic [3:0] OPC_SECOND_WORD = 4'hf;   // Second word top nibble 1111.
    localparam int unsigned OPC_HI = 15;            // Top bit of the opcode field.
    localparam int unsigned OPC9_LO = 7;            // Low bit of the nine-bit first opcode.
    localparam int unsigned OPC4_LO = 12;           // Low bit of the second word nibble.
    localparam int unsigned OFFS_HI = 6;            // Top bit of the offset field.
    localparam int unsigned FILE_HI = 11;           // Top bit of the file address field.

    // ****************************************************************
    // Phases of the instruction cycle.
    // ****************************************************************
    localparam logic [1:0] PH_Q1 = 2'h0; // Decode phase.
    localparam logic [1:0] PH_Q2 = 2'h1; // First address phase.
    localparam logic [1:0] PH_Q3 = 2'h2; // Second address phase.
    localparam logic [1:0] PH_Q4 = 2'h3; // Memory access phase.

    // Zero byte returned for an indirect source.
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Sequencer states.
    typedef enum logic [1:0] {
        IMI_IDLE = 2'b00, // Waiting for a first word.
        IMI_SRC  = 2'b01, // First cycle: source address and read.
        IMI_DST  = 2'b10  // Second cycle: destination and write.
    } imi_state_t;

endpackage

// File: imi_mem_model.sv
// Data memory model that answers the indexed move block.
`timescale 1ns/1ps
`default_nettype none

module imi_mem_model (
    input  wire logic        clk_sys_i, // System clock.
    input  wire logic [11:0] addr_i,    // Byte address.
    input  wire logic        rd_i,      // Read strobe.
    input  wire logic        wr_i,      // Write strobe.
    input  wire logic [7:0]  wr_data_i, // Write byte.
    output logic      [7:0]  rd_data_o  // Read byte.
);
    logic [7:0] mem [0:4095]; // Byte array of the whole data space.
    logic [7:0] pat_ff = 8'h5a; // Filler that changes every cycle.

    // Writes land at the sampling edge; the filler keeps moving so a stale read never matches.
    always @(posedge clk_sys_i) begin
        pat_ff <= ~pat_ff + 8'h01;
        if (wr_i) begin
            mem[addr_i] <= wr_data_i;
        end
    end

    // Read data is shown only while the read strobe is up.
    assign rd_data_o = rd_i ? mem[addr_i] : pat_ff;
endmodule

`default_nettype wire

// File: tb.sv
// Self-checking testbench for the indexed move decoder.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import imi_pkg::*;

    logic        clk_sys_i = 1'b0; // System clock.
    logic        rst_i = 1'b1;     // Synchronous reset.
    logic        valid = 1'b0;     // Word offered.
    logic [15:0] word = 16'h0000;  // Program word.
    logic [11:0] fp = 12'h000;     // Frame pointer.
    logic [7:0]  rd_data;          // Memory read byte.
    logic [1:0]  q_phase;          // Phase seen.
    logic        claim, busy, rd, wr;
    logic [11:0] addr;             // Memory address.
    logic [7:0]  wr_data;          // Memory write byte.
    int          err_total = 0, comparisons = 0, rd_n, wr_n, cyc = 0;
    logic [11:0] rd_a, wr_a;       // Addresses seen at the strobes.

    always #2 clk_sys_i = ~clk_sys_i;

    imi_decoder uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_valid_i(valid), .instr_word_i(word),
        .frame_ptr_i(fp), .mem_rd_data_i(rd_data), .q_phase_o(q_phase), .claim_o(claim), .busy_o(busy),
        .mem_addr_o(addr), .mem_rd_o(rd), .mem_wr_o(wr), .mem_wr_data_o(wr_data));
    imi_mem_model u_mem (.clk_sys_i(clk_sys_i), .addr_i(addr), .rd_i(rd), .wr_i(wr),
        .wr_data_i(wr_data), .rd_data_o(rd_data));

    // Strobes are counted at the edge that samples them; a hang is cut short.
    always @(posedge clk_sys_i) begin
        cyc++;
        if (rd === 1'b1) begin rd_n++; rd_a = addr; end
        if (wr === 1'b1) begin wr_n++; wr_a = addr; end
        if (cyc == 3000) begin err_total++; summarize(); end
    end

    // Compares one value and counts the outcome.
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Offers one word in Q1 and checks the claim.
    task automatic offer(input logic [15:0] w, input logic exp_claim);
        int n;
        n = 0;
        while (q_phase !== PH_Q1 && n < 8) begin @(posedge clk_sys_i); #1; n++; end
        valid = 1'b1;
        word = w;
        #1 chk("claim", exp_claim, claim);
        @(posedge clk_sys_i); #1;
        valid = 1'b0;
    endtask

    // Runs a two-word move, then waits past the second Q4.
    task automatic run(input logic [15:0] w1, input logic [15:0] w2, input logic [11:0] p, input int exp_rd);
        fp = p;
        rd_n = 0;
        wr_n = 0;
        offer(w1, 1'b1);
        chk("busy", 1, busy);
        chk("phase", PH_Q2, q_phase);
        repeat (3) begin @(posedge clk_sys_i); #1; end
        chk("read count", exp_rd, rd_n);
        offer(w2, 1'b1);
        chk("write count", 0, wr_n);
        repeat (3) begin @(posedge clk_sys_i); #1; end
    endtask

    // Indexed to indexed move with its expected outcome.
    task automatic move(input logic [11:0] p, input logic [6:0] zs, input logic [6:0] zd, input logic [7:0] v);
        logic [11:0] s, d;
        logic        is_s, is_d;
        s = p + zs;
        d = p + zd;
        is_s = s >= 12'hfe0 && s <= 12'hfef;
        is_d = d >= 12'hfe0 && d <= 12'hfef;
        u_mem.mem[s] = v;
        u_mem.mem[d] = 8'h11;
        // destination never a program counter or stack byte
        run({OPC_IDX_TO_IDX, zs}, {4'hf, 5'h15, zd}, p, is_s ? 0 : 1);
        chk("reads", is_s ? 0 : 1, rd_n);
        if (!is_s) chk("read addr", s, rd_a);
        chk("writes", is_d ? 0 : 1, wr_n);
        if (!is_d) chk("write addr", d, wr_a);
        chk("dest byte", is_d ? 8'h11 : (is_s ? 8'h00 : v), u_mem.mem[d]);
    endtask

    task automatic t_basic;
        move(12'h080, 7'h05, 7'h06, 8'h33);
        @(posedge clk_sys_i); #1;
        chk("idle", 0, busy);
        $display("t_basic done");
    endtask

    task automatic t_bounds;
        move(12'hf80, 7'h7f, 7'h00, 8'ha5);
        move(12'h000, 7'h00, 7'h7f, 8'h3c);
        move(12'hfa0, 7'h7f, 7'h7e, 8'hc3);
        $display("t_bounds done");
    endtask

    task automatic t_indirect;
        move(12'hfd0, 7'h15, 7'h00, 8'h77);
        move(12'hfd0, 7'h00, 7'h10, 8'h66);
        $display("t_indirect done");
    endtask

    task automatic t_file;
        u_mem.mem[12'h085] = 8'h33;
        u_mem.mem[12'h2c4] = 8'h11;
        run({OPC_IDX_TO_FILE, 7'h05}, 16'hf2c4, 12'h080, 1);
        chk("file writes", 1, wr_n);
        chk("file addr", 12'h2c4, wr_a);
        chk("file byte", 8'h33, u_mem.mem[12'h2c4]);
        $display("t_file done");
    endtask

    task automatic t_lone;
        while (busy === 1'b1) begin @(posedge clk_sys_i); #1; end
        rd_n = 0;
        wr_n = 0;
        offer(16'hf123, 1'b0);
        repeat (8) begin @(posedge clk_sys_i); #1; end
        chk("lone strobes", 0, rd_n + wr_n);
        chk("lone busy", 0, busy);
        $display("t_lone done");
    endtask

    // A first word followed by anything but a second word is dropped with no write.
    task automatic t_drop;
        wr_n = 0;
        offer({OPC_IDX_TO_IDX, 7'h05}, 1'b1);
        repeat (3) begin @(posedge clk_sys_i); #1; end
        offer(16'h0000, 1'b0);
        repeat (4) begin @(posedge clk_sys_i); #1; end
        chk("drop writes", 0, wr_n);
        chk("drop busy", 0, busy);
        $display("t_drop done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence: reset for eight cycles, then every scenario.
    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1 rst_i = 1'b0;
        t_basic();
        t_bounds();
        t_indirect();
        t_file();
        t_lone();
        t_drop();
        summarize();
    end
endmodule

`default_nettype wire
